/* File: hw/tag_telegram_top.sv */
// Read-only tag: telegram reader, bi-phase encoder and damping load drive
//
// Operation
// - Repeat telegram continuously while field present
// - 128-bit fused code shifted out bitwise
// - Next repetition follows last bit without gap
// - Each bit cell lasts 32 carrier cycles
// - Zero inverts subcarrier phase, one keeps it
// - Rising edges advanced up to eight cycles
// - Damping load switched by encoded stream
// - Single, double or alternate side loading option
// - Header of zeros then a single one
// - 64-bit code as eight 8-bit blocks
// - 16 check bits as two blocks
// - Check bits cover only the code
// - 24 trailer bits as three blocks
// - Control bit one after every block
// - Code, check, trailer sent LSB first
// - Transmit only while field is on
`timescale 1ns/10ps
module tag_telegram_top #(
  parameter logic [tag_pkg::ID_BITS-1:0]      ID_CODE   = 64'h0000_0000_0000_0000,
  parameter logic [tag_pkg::CRC_BITS-1:0]     CRC_CODE  = 16'h0000,
  parameter logic [tag_pkg::TRAILER_BITS-1:0] TRAILER   = 24'h00_0000,
  parameter tag_pkg::load_mode_t              LOAD_MODE = tag_pkg::LOAD_SINGLE,
  parameter int                               ADVANCE   = tag_pkg::MAX_ADVANCE
) (
  // Clock and power-up reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Field sensing
  input  wire logic field_present,
  input  wire logic carrier_in,
  // Damping load drive
  output logic      load_coil1_q,
  output logic      load_coil2_q,
  // Status
  output logic      sending_q
);
  import tag_pkg::*;

  // ****************************************************************
  // Fuse image
  // ****************************************************************
  // The check bits are programmed with the code, computed over the code
  // alone; the tag never recomputes them.
  localparam logic [TELEGRAM_BITS-1:0] FUSES =
    build_telegram(ID_CODE, CRC_CODE, TRAILER);

  // Clamp keeps the delay tap inside the history register
  localparam int ADV = (ADVANCE < 1) ? 1 : ((ADVANCE > MAX_ADVANCE) ? MAX_ADVANCE : ADVANCE);

  // ****************************************************************
  // Telegram reader
  // ****************************************************************
  logic [INDEX_BITS-1:0] idx_q, idx_d;
  logic                  fifo_in_ready;
  logic                  fifo_push;
  logic                  fifo_out_valid;
  logic                  fifo_pop;
  logic [0:0]            fifo_out_data;
  logic                  flush;

  // Leaving the field drops anything queued, so a new field starts fresh
  assign flush     = !field_present;
  assign fifo_push = field_present;

  always_comb begin
    idx_d = idx_q;
    if (!field_present) begin
      idx_d = INDEX_RESET;
    end else if (fifo_in_ready) begin
      // Index wraps from 127 to 0 with no idle bit in between
      idx_d = INDEX_BITS'(idx_q + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= INDEX_RESET;
    end else begin
      idx_q <= idx_d;
    end
  end

  // ****************************************************************
  // Bit buffer
  // ****************************************************************
  // The reader stalls whenever the buffer is full, so it runs at most eight bits
  // ahead of the slow bit cells without losing its place.
  bit_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (flush),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (FUSES[idx_q]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // ****************************************************************
  // Carrier edge detect
  // ****************************************************************
  logic carrier_q, carrier_d;
  logic carrier_edge;

  always_comb begin
    carrier_d = carrier_in;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carrier_q <= 1'b0;
    end else begin
      carrier_q <= carrier_d;
    end
  end

  assign carrier_edge = carrier_in && !carrier_q;

  // ****************************************************************
  // Differential bi-phase encoder
  // ****************************************************************
  enc_state_t            state_q, state_d;
  logic [CYC_BITS-1:0]   cyc_q, cyc_d;
  logic                  ideal_q, ideal_d;
  logic [7:0]            hist_q, hist_d;
  logic                  cell_start;
  logic                  next_bit;

  assign next_bit = fifo_out_valid ? fifo_out_data[0] : 1'b0;

  always_comb begin
    state_d    = state_q;
    cyc_d      = cyc_q;
    ideal_d    = ideal_q;
    hist_d     = hist_q;
    cell_start = 1'b0;
    case (state_q)
      ENC_IDLE: begin
        if (field_present && fifo_out_valid && carrier_edge) begin
          state_d    = ENC_SEND;
          cell_start = 1'b1;
        end
      end
      ENC_SEND: begin
        if (!field_present) begin
          state_d = ENC_IDLE;
        end else if (carrier_edge) begin
          cell_start = (cyc_q == CYC_BITS'(CELL_CYCLES-1));
        end
      end
      default: begin
        state_d = ENC_IDLE;
      end
    endcase

    if (state_d == ENC_IDLE) begin
      cyc_d   = CYC_RESET;
      ideal_d = 1'b0;
      hist_d  = HIST_RESET;
    end else if (carrier_edge) begin
      hist_d = {hist_q[6:0], ideal_q};
      if (cell_start) begin
        // Count runs 0..31 over the cell, so a cell spans 32 carrier edges
        cyc_d = CYC_RESET;
        // The subcarrier toggles at the boundary before a zero; a one skips it
        if (!next_bit) begin
          ideal_d = !ideal_q;
        end
      end else begin
        cyc_d = CYC_BITS'(cyc_q + 1'b1);
        if (cyc_q == CYC_BITS'(HALF_CELL-1)) begin
          ideal_d = !ideal_q;
        end
      end
    end
  end

  // Pop exactly one bit at each cell start
  assign fifo_pop = cell_start;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ENC_IDLE;
      cyc_q   <= CYC_RESET;
      ideal_q <= 1'b0;
      hist_q  <= HIST_RESET;
    end else begin
      state_q <= state_d;
      cyc_q   <= cyc_d;
      ideal_q <= ideal_d;
      hist_q  <= hist_d;
    end
  end

  // ****************************************************************
  // Edge advance and load drive
  // ****************************************************************
  // ORing the wave with a delayed copy stretches each high phase at its
  // end; against the delayed copy every rise comes ADV cycles early while
  // the period is untouched. Costs a fixed lag of ADV carrier cycles.
  logic mod_level;
  logic coil1_d, coil2_d, sending_d;

  assign mod_level = (state_q == ENC_SEND) && (ideal_q || hist_q[ADV-1]);

  always_comb begin
    coil1_d   = 1'b0;
    coil2_d   = 1'b0;
    sending_d = (state_q == ENC_SEND);
    case (LOAD_MODE)
      LOAD_SINGLE: begin
        coil1_d = mod_level;
      end
      LOAD_DOUBLE: begin
        coil1_d = mod_level;
        coil2_d = mod_level;
      end
      LOAD_ALTERNATE: begin
        // Side follows the carrier half-wave
        coil1_d = mod_level && carrier_in;
        coil2_d = mod_level && !carrier_in;
      end
      default: begin
        coil1_d = mod_level;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_coil1_q <= 1'b0;
      load_coil2_q <= 1'b0;
      sending_q    <= 1'b0;
    end else begin
      load_coil1_q <= coil1_d;
      load_coil2_q <= coil2_d;
      sending_q    <= sending_d;
    end
  end

endmodule : tag_telegram_top

/* File: inc/tag_pkg.sv */
// Constants, types and the telegram builder shared by the tag logic
package tag_pkg;

  // ****************************************************************
  // Telegram layout
  // ****************************************************************
  localparam int TELEGRAM_BITS = 128;
  localparam int HEADER_ZEROS  = 10;
  localparam int HEADER_BITS   = 11;
  localparam int ID_BITS       = 64;
  localparam int CRC_BITS      = 16;
  localparam int TRAILER_BITS  = 24;
  localparam int BLOCK_BITS    = 8;
  localparam int PAYLOAD_BITS  = ID_BITS + CRC_BITS + TRAILER_BITS;
  localparam int BLOCK_COUNT   = PAYLOAD_BITS / BLOCK_BITS;
  localparam int INDEX_BITS    = 7;

  // ****************************************************************
  // Bit cell timing, in carrier cycles
  // ****************************************************************
  localparam int CELL_CYCLES   = 32;
  localparam int HALF_CELL     = 16;
  localparam int MAX_ADVANCE   = 8;
  localparam int CYC_BITS      = 5;

  // ****************************************************************
  // Buffering
  // ****************************************************************
  localparam int FIFO_DEPTH    = 8;
  localparam int FIFO_WIDTH    = 1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [INDEX_BITS-1:0] INDEX_RESET = 7'h00;
  localparam logic [CYC_BITS-1:0]   CYC_RESET   = 5'h00;
  localparam logic [7:0]            HIST_RESET  = 8'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    LOAD_SINGLE,
    LOAD_DOUBLE,
    LOAD_ALTERNATE
  } load_mode_t;

  typedef enum logic {
    ENC_IDLE,
    ENC_SEND
  } enc_state_t;

  // Bit 0 of the result goes out first
  function automatic logic [TELEGRAM_BITS-1:0] build_telegram(
    input logic [ID_BITS-1:0]      id_code,
    input logic [CRC_BITS-1:0]     crc_code,
    input logic [TRAILER_BITS-1:0] trailer
  );
    logic [TELEGRAM_BITS-1:0] t;
    logic [PAYLOAD_BITS-1:0]  p;
    int                       pos;
    t   = '0;
    p   = {trailer, crc_code, id_code};
    pos = HEADER_ZEROS;
    t[pos] = 1'b1;
    pos = HEADER_BITS;
    for (int b = 0; b < BLOCK_COUNT; b++) begin
      for (int i = 0; i < BLOCK_BITS; i++) begin
        t[pos] = p[b*BLOCK_BITS+i];
        pos    = pos + 1;
      end
      t[pos] = 1'b1;
      pos    = pos + 1;
    end
    return t;
  endfunction : build_telegram

endpackage : tag_pkg

/* File: hw/bit_fifo.sv */
// Small flip-flop FIFO between the telegram reader and the encoder
`timescale 1ns/10ps
module bit_fifo #(
  parameter int WIDTH = tag_pkg::FIFO_WIDTH,
  parameter int DEPTH = tag_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  import tag_pkg::*;

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [PW:0]      cnt_q, cnt_d;
  logic             push, pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH-1)) ? '0 : PW'(p + 1'b1);
  endfunction : bump

  assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (flush) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end else begin
      if (push) begin
        mem_d[wr_q] = in_data;
        wr_d        = bump(wr_q);
      end
      if (pop) begin
        rd_d = bump(rd_q);
      end
      cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule : bit_fifo

/* File: tb/tag_telegram_properties.sv */
// Concurrent checks on the ports of the tag top
`timescale 1ns/10ps
module tag_telegram_properties
  import tag_pkg::*;
#(
  parameter tag_pkg::load_mode_t LOAD_MODE = tag_pkg::LOAD_SINGLE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic field_present,
  input wire logic carrier_in,
  input wire logic load_coil1_q,
  input wire logic load_coil2_q,
  input wire logic sending_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************
  // Checks
  // ****************
  chk_reset_clear: assert property (!$past(rst_n) |-> !sending_q && !load_coil1_q)
    else $error("outputs not clear after reset");
  chk_idle_quiet: assert property (!field_present [*2] |=>
    !sending_q && !load_coil1_q && !load_coil2_q) else $error("activity without field");
  // The start edge lies two samples before the rise of the registered flag
  chk_send_start: assert property ($rose(sending_q) |-> $past(field_present, 2) &&
    $past(carrier_in, 2) && !$past(carrier_in, 3)) else $error("start not on carrier edge");
  chk_send_holds: assert property (sending_q && field_present |=> sending_q)
    else $error("sending dropped with field on");
  chk_load_gated: assert property (load_coil1_q |-> sending_q || $past(sending_q))
    else $error("load without sending");
  chk_double_same: assert property (LOAD_MODE == LOAD_DOUBLE |->
    load_coil1_q == load_coil2_q) else $error("coil sides differ");
  // Outside alternate mode, changes follow the carrier edge by the register pipeline only
  chk_load_timing: assert property ($changed(load_coil1_q) && field_present &&
    $past(field_present) |-> $past(carrier_in, 2) && !$past(carrier_in, 3))
    else $error("load moved off a carrier edge");
  // Mid-cell inversion bounds any run, even with the rise advance
  chk_cell_toggle: assert property ($changed(load_coil1_q) && sending_q |->
    ##[1:260] ($changed(load_coil1_q) || !field_present)) else $error("load stuck");
endmodule : tag_telegram_properties

/* File: tb/reader_model.sv */
// Reader station: activation field and carrier towards the tag
`timescale 1ns/10ps
module reader_model (
  // Clock
  input  wire logic       clk,
  // Bench control
  input  wire logic       field_cmd,
  input  wire logic [1:0] half,
  // Field towards the tag
  output logic            field_present = 1'b0,
  output logic            carrier_in    = 1'b0
);
  int n = 0;
  // Carrier stands still between activations and starts a few cycles late
  always @(negedge clk) begin
    // Activation windows are kept to about one telegram or less to keep runs brief
    field_present <= field_cmd;
    if (!field_cmd) begin
      carrier_in <= 1'b0;
      n          <= -3;
    end else if (n + 1 >= half) begin
      carrier_in <= ~carrier_in;
      n          <= 0;
    end else begin
      n <= n + 1;
    end
  end
endmodule : reader_model

/* File: tb/tb.sv */
// Self-checking bench for the tag telegram top
`timescale 1ns/10ps
module tb;
  import tag_pkg::*;
  localparam logic [ID_BITS-1:0]      ID  = 64'h3c5a_0f96_e1d2_7b48;
  localparam logic [CRC_BITS-1:0]     CRC = 16'ha5c3;
  localparam logic [TRAILER_BITS-1:0] TRL = 24'h81_7e42;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd   = 1'b0;
  logic [1:0]  half  = 2'h2;
  logic [31:0] lf    = 32'h0000_8b05;
  logic        field_present, carrier_in, load_coil1_q, load_coil2_q, sending_q;
  logic        q[$];
  logic [2:0]  e     = 3'h0;
  logic [4:0]  k     = 5'h00;
  logic        pc    = 1'b0, on = 1'b0, skip = 1'b0, l12 = 1'b0, p28 = 1'b0, l20 = 1'b0;
  int          c, cyc, fail_count, check_count;

  always #10 clk = ~clk;

  reader_model rd_u (.clk(clk), .field_cmd(cmd), .half(half),
    .field_present(field_present), .carrier_in(carrier_in));
  tag_telegram_top #(.ID_CODE(ID), .CRC_CODE(CRC), .TRAILER(TRL),
    .LOAD_MODE(LOAD_DOUBLE)) dut_u (.clk(clk), .rst_n(rst_n),
    .field_present(field_present), .carrier_in(carrier_in), .load_coil1_q(load_coil1_q),
    .load_coil2_q(load_coil2_q), .sending_q(sending_q));

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic eb(int i);
    logic [PAYLOAD_BITS-1:0] p;
    int                      j;
    p = {TRL, CRC, ID};
    j = i - HEADER_BITS;
    if (i < HEADER_BITS) return i == HEADER_BITS - 1;
    if (j % 9 == BLOCK_BITS) return 1'b1;
    return p[(j / 9) * BLOCK_BITS + j % 9];
  endfunction : eb

  task automatic check(string name, logic seen, logic exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", name, exp, seen);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // Notes the bits of one activation, then drops the field
  task automatic run(int n, int first, int t);
    for (int i = 0; i < n; i++) begin
      q.push_back(eb((first + i) % TELEGRAM_BITS));
    end
    cmd <= 1'b1;
    while (q.size() > 0) begin
      @(negedge clk);
    end
    cmd <= 1'b0;
    repeat (4) @(negedge clk);
    check("sending", sending_q, 1'b0);
    check("coil", load_coil1_q | load_coil2_q, 1'b0);
    $display("test %0d done", t);
  endtask : run

  // ****************
  // Stimulus
  // ****************
  always @(negedge clk) begin
    lf   <= lfsr(lf);
    half <= 2'h2 + {1'b0, lf[0]};
  end

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    run(138, 0, 1);
    skip = 1'b1;
    run(20 + lf[5:0], 1, 2);
    run(24, 1, 3);
    summarize();
  end

  // ****************
  // Decoder and compare
  // ****************
  // Level is taken well clear of both toggles, so the rise advance cannot blur it
  always @(posedge clk) begin
    e  = {e[1:0], carrier_in & ~pc & field_present};
    pc = carrier_in;
    if (!field_present) begin
      on = 1'b0;
    end else if (e[2]) begin
      k = on ? k + 5'h01 : 5'h00;
      if (!on) begin
        c   = 0;
        p28 = 1'b0;
      end
      on = 1'b1;
      if (k == 5'h0c) l12 = load_coil1_q;
      if (k == 5'h14) l20 = load_coil1_q;
      if (k == 5'h1c) begin
        // Four edges past the mid toggle a high first half must still show
        check("advance", l20, l12 | load_coil1_q);
        check("active", sending_q, 1'b1);
        // Later runs queue bits from index 1, so cell 0 is skipped
        if (c > 0 || !skip) begin
          if (q.size() == 0) check("queue", 1'b1, 1'b0);
          else check("bit", l12 === p28, q.pop_front());
        end
        p28 = load_coil1_q;
        c++;
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      summarize();
    end
  end
endmodule : tb

bind tag_telegram_top tag_telegram_properties #(.LOAD_MODE(LOAD_MODE)) chk_u (.clk(clk),
  .rst_n(rst_n), .field_present(field_present), .carrier_in(carrier_in),
  .load_coil1_q(load_coil1_q), .load_coil2_q(load_coil2_q), .sending_q(sending_q));
